// file: pkg/ffrc_pkg.sv
/*
 constants for the reset, strap capture and reread control of a
 bus-matching fifo. assumes all inputs come from host logic on the same
 clock as the block.
*/
package ffrc_pkg;
    localparam int DATA_W = 36;
    localparam int OFS_W = 16;
    // port width codes
    localparam logic [1:0] WID_36 = 2'h0;
    localparam logic [1:0] WID_18 = 2'h1;
    localparam logic [1:0] WID_9 = 2'h2;
    // strap levels at full reset
    localparam logic LVL_BIG = 1'h0;
    localparam logic LVL_ZERO_LAT = 1'h0;
    localparam logic LVL_FALL_THROUGH = 1'h1;
    localparam logic LVL_INTERSPERSED = 1'h1;
    localparam logic LVL_SERIAL_LOAD = 1'h1;
    // reset values
    localparam logic [DATA_W-1:0] RST_WORD = 36'h0;
    localparam logic [1:0] RST_WIDTH = 2'h0;
    // default offsets indexed by {select_1, select_0, offset_access}
    localparam logic [OFS_W-1:0] DEF_OFS [8] = '{16'h0007, 16'h000f, 16'h001f,
        16'h003f, 16'h007f, 16'h00ff, 16'h01ff, 16'h03ff};
endpackage

// file: rtl/ffrc_top.sv
/*
 reset, strap capture, bus matching and reread control of a fifo with a
 small word store. assumes one clock; host logic drives resets, straps,
 enables and data synchronously to i_clk.
*/
`timescale 1ns/10ps
module ffrc_top #(
    parameter int DEPTH = 16
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_full_reset_n,
    input wire logic i_partial_reset_n,
    input wire logic i_reread_req_n,
    input wire logic i_fallthrough_select_serial_in,
    input wire logic i_width_match_select,
    input wire logic i_write_width_select,
    input wire logic i_read_width_select,
    input wire logic i_byte_order_select,
    input wire logic i_reread_latency_select,
    input wire logic i_almost_flag_timing_select,
    input wire logic i_parity_placement_select,
    input wire logic i_default_offset_select_0,
    input wire logic i_default_offset_select_1,
    input wire logic i_offset_access_enable_n,
    input wire logic i_serial_en_n,
    input wire logic i_write_en_n,
    input wire logic [35:0] i_write_data_lines,
    input wire logic i_read_en_n,
    output logic [35:0] o_read_data,
    output logic o_empty_indicator_n,
    output logic o_fall_through_mode,
    output logic [1:0] o_write_width,
    output logic [1:0] o_read_width,
    output logic o_byte_order,
    output logic o_reread_latency,
    output logic o_almost_flag_timing,
    output logic o_parity_placement,
    output logic [2:0] o_default_offset_sel,
    output logic o_serial_load_mode,
    output logic [15:0] o_empty_offset,
    output logic [15:0] o_full_offset
);
    localparam int AW = $clog2(DEPTH);
    localparam int PW = AW + 1;

    function automatic logic [1:0] last_idx(input logic [1:0] w);
        if (w == ffrc_pkg::WID_18) begin
            return 2'h1;
        end
        if (w == ffrc_pkg::WID_9) begin
            return 2'h3;
        end
        return 2'h0;
    endfunction

    function automatic logic [35:0] put_piece(input logic [35:0] acc, input logic [35:0] d,
                                              input logic [1:0] w, input logic [1:0] p);
        logic [35:0] r;
        r = acc;
        if (w == ffrc_pkg::WID_18) begin
            r[18*p +: 18] = d[17:0];
        end else if (w == ffrc_pkg::WID_9) begin
            r[9*p +: 9] = d[8:0];
        end else begin
            r = d;
        end
        return r;
    endfunction

    function automatic logic [35:0] get_piece(input logic [35:0] word, input logic [1:0] w,
                                              input logic [1:0] p);
        if (w == ffrc_pkg::WID_18) begin
            return {18'h0, word[18*p +: 18]};
        end
        if (w == ffrc_pkg::WID_9) begin
            return {27'h0, word[9*p +: 9]};
        end
        return word;
    endfunction

    function automatic logic [15:0] ofs_of(input logic [35:0] d, input logic inter);
        logic [31:0] v;
        v = d[31:0];
        if (inter == ffrc_pkg::LVL_INTERSPERSED) begin
            v = {d[34:27], d[25:18], d[16:9], d[7:0]};
        end
        return v[ffrc_pkg::OFS_W-1:0];
    endfunction

    logic [35:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [1:0] wsub, rsub, next_wsub, next_rsub;
    logic [35:0] wacc, next_wacc, next_read_data;
    logic out_valid, next_out_valid, next_empty_n, ofs_sel, next_ofs_sel;
    logic commit;
    logic next_ft, next_order, next_lat, next_aft, next_par, next_serial;
    logic [1:0] next_ww, next_rw;
    logic [2:0] next_dsel;
    logic [15:0] next_eofs, next_fofs;

    // configuration and offsets
    always_comb begin
        next_ft = o_fall_through_mode;
        next_ww = o_write_width;
        next_rw = o_read_width;
        next_order = o_byte_order;
        next_lat = o_reread_latency;
        next_aft = o_almost_flag_timing;
        next_par = o_parity_placement;
        next_dsel = o_default_offset_sel;
        next_serial = o_serial_load_mode;
        next_eofs = o_empty_offset;
        next_fofs = o_full_offset;
        next_ofs_sel = ofs_sel;
        if (!i_full_reset_n) begin
            next_ft = i_fallthrough_select_serial_in;
            next_ww = ffrc_pkg::WID_36;
            next_rw = ffrc_pkg::WID_36;
            if (i_width_match_select) begin
                unique case ({i_write_width_select, i_read_width_select})
                    2'h0: next_rw = ffrc_pkg::WID_18;
                    2'h1: next_rw = ffrc_pkg::WID_9;
                    2'h2: next_ww = ffrc_pkg::WID_18;
                    2'h3: next_ww = ffrc_pkg::WID_9;
                endcase
            end
            next_order = i_byte_order_select;
            next_lat = i_reread_latency_select;
            next_aft = i_almost_flag_timing_select;
            next_par = i_parity_placement_select;
            next_dsel = {i_default_offset_select_1, i_default_offset_select_0,
                         i_offset_access_enable_n};
            next_serial = (i_offset_access_enable_n == ffrc_pkg::LVL_SERIAL_LOAD);
            next_eofs = ffrc_pkg::DEF_OFS[next_dsel];
            next_fofs = ffrc_pkg::DEF_OFS[next_dsel];
            next_ofs_sel = 1'h0;
        end else if (!i_offset_access_enable_n && i_partial_reset_n) begin
            if (o_serial_load_mode && !i_serial_en_n) begin
                // serial bit shifts through empty then full offset
                {next_fofs, next_eofs} = {o_full_offset[14:0], o_empty_offset,
                                          i_fallthrough_select_serial_in};
            end else if (!o_serial_load_mode && !i_write_en_n) begin
                if (ofs_sel) begin
                    next_fofs = ofs_of(i_write_data_lines, o_parity_placement);
                end else begin
                    next_eofs = ofs_of(i_write_data_lines, o_parity_placement);
                end
                next_ofs_sel = !ofs_sel;
            end
        end
    end

    // store, pointers and output register
    always_comb begin
        logic [1:0] wp;
        logic [1:0] rp;
        logic rd_go;
        logic empty;
        wp = 2'h0;
        rp = 2'h0;
        rd_go = 1'h0;
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_wsub = wsub;
        next_rsub = rsub;
        next_wacc = wacc;
        next_read_data = o_read_data;
        next_out_valid = out_valid;
        commit = 1'h0;
        empty = (wr_ptr == rd_ptr);
        if (!i_write_en_n && i_offset_access_enable_n
            && (wr_ptr - rd_ptr) != PW'(DEPTH)) begin
            wp = (o_byte_order == ffrc_pkg::LVL_BIG) ?
                 last_idx(o_write_width) - wsub : wsub;
            next_wacc = put_piece(wacc, i_write_data_lines, o_write_width, wp);
            next_wsub = wsub + 2'h1;
            if (wsub == last_idx(o_write_width)) begin
                commit = 1'h1;
                next_wsub = 2'h0;
                next_wr_ptr = wr_ptr + PW'(1);
            end
        end
        rd_go = !empty && i_offset_access_enable_n && (o_fall_through_mode ?
                (!out_valid || !i_read_en_n) : !i_read_en_n);
        if (!i_reread_req_n) begin
            next_rd_ptr = '0;
            next_rsub = 2'h0;
            next_out_valid = 1'h0;
            if (o_reread_latency == ffrc_pkg::LVL_ZERO_LAT) begin
                rp = (o_byte_order == ffrc_pkg::LVL_BIG) ? last_idx(o_read_width) : 2'h0;
                next_read_data = get_piece(mem[0], o_read_width, rp);
                next_out_valid = 1'h1;
                next_rsub = 2'h1;
                if (last_idx(o_read_width) == 2'h0) begin
                    next_rsub = 2'h0;
                    next_rd_ptr = PW'(1);
                end
            end
        end else if (rd_go) begin
            rp = (o_byte_order == ffrc_pkg::LVL_BIG) ?
                 last_idx(o_read_width) - rsub : rsub;
            next_read_data = get_piece(mem[rd_ptr[AW-1:0]], o_read_width, rp);
            next_out_valid = 1'h1;
            next_rsub = rsub + 2'h1;
            if (rsub == last_idx(o_read_width)) begin
                next_rsub = 2'h0;
                next_rd_ptr = rd_ptr + PW'(1);
            end
        end else if (!i_read_en_n) begin
            next_out_valid = 1'h0;
        end
        if (!i_full_reset_n || !i_partial_reset_n) begin
            next_wr_ptr = '0;
            next_rd_ptr = '0;
            next_wsub = 2'h0;
            next_rsub = 2'h0;
            next_wacc = ffrc_pkg::RST_WORD;
            next_read_data = ffrc_pkg::RST_WORD;
            next_out_valid = 1'h0;
            commit = 1'h0;
        end
        next_empty_n = o_fall_through_mode ? !next_out_valid : (next_wr_ptr != next_rd_ptr);
        if (!i_reread_req_n && i_full_reset_n && i_partial_reset_n) begin
            next_empty_n = o_fall_through_mode;
        end
    end

    always_ff @(posedge i_clk) begin
        if (commit) begin
            mem[wr_ptr[AW-1:0]] <= next_wacc;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            wsub <= 2'h0;
            rsub <= 2'h0;
            wacc <= ffrc_pkg::RST_WORD;
            o_read_data <= ffrc_pkg::RST_WORD;
            out_valid <= 1'h0;
            o_empty_indicator_n <= 1'h0;
            o_fall_through_mode <= 1'h0;
            o_write_width <= ffrc_pkg::RST_WIDTH;
            o_read_width <= ffrc_pkg::RST_WIDTH;
            o_byte_order <= 1'h0;
            o_reread_latency <= 1'h0;
            o_almost_flag_timing <= 1'h0;
            o_parity_placement <= 1'h0;
            o_default_offset_sel <= 3'h0;
            o_serial_load_mode <= 1'h0;
            o_empty_offset <= ffrc_pkg::DEF_OFS[0];
            o_full_offset <= ffrc_pkg::DEF_OFS[0];
            ofs_sel <= 1'h0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            wsub <= next_wsub;
            rsub <= next_rsub;
            wacc <= next_wacc;
            o_read_data <= next_read_data;
            out_valid <= next_out_valid;
            o_empty_indicator_n <= next_empty_n;
            o_fall_through_mode <= next_ft;
            o_write_width <= next_ww;
            o_read_width <= next_rw;
            o_byte_order <= next_order;
            o_reread_latency <= next_lat;
            o_almost_flag_timing <= next_aft;
            o_parity_placement <= next_par;
            o_default_offset_sel <= next_dsel;
            o_serial_load_mode <= next_serial;
            o_empty_offset <= next_eofs;
            o_full_offset <= next_fofs;
            ofs_sel <= next_ofs_sel;
        end
    end

    // checks
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    wire run = i_full_reset_n && i_partial_reset_n;
    wire [35:0] first_word = mem[0];
    wire [8:0] cfg_all = {o_fall_through_mode, o_write_width, o_read_width, o_byte_order,
                          o_reread_latency, o_almost_flag_timing, o_parity_placement};

    sequence reread_seq;
        run && !i_reread_req_n;
    endsequence

    full_rst_clear_a: assert property (!i_full_reset_n |=>
        rd_ptr == '0 && wr_ptr == '0 && o_read_data == '0)
        else $error("full reset left pointers or output set");
    part_rst_keep_a: assert property (i_full_reset_n && !i_partial_reset_n |=>
        rd_ptr == '0 && o_read_data == '0 && $stable(cfg_all) && $stable(o_empty_offset))
        else $error("partial reset cleared wrong state");
    reread_ptr_a: assert property (reread_seq ##0 o_reread_latency |=>
        rd_ptr == '0 && rsub == 2'h0)
        else $error("reread did not rewind read pointer");
    reread_flag_a: assert property (reread_seq |=>
        o_empty_indicator_n == o_fall_through_mode)
        else $error("reread flag level wrong");
    zero_lat_word_a: assert property (reread_seq ##0 !o_reread_latency
        ##0 o_read_width == ffrc_pkg::WID_36 |=> o_read_data == $past(first_word))
        else $error("zero latency reread word missing");
    width_match_a: assert property (!i_full_reset_n && !i_width_match_select |=>
        o_write_width == ffrc_pkg::WID_36 && o_read_width == ffrc_pkg::WID_36)
        else $error("width decode wrong without match");
    cfg_hold_a: assert property (i_full_reset_n |=> $stable(cfg_all))
        else $error("configuration changed outside full reset");
    order_capture_a: assert property (!i_full_reset_n |=>
        o_byte_order == $past(i_byte_order_select)
        && o_reread_latency == $past(i_reread_latency_select))
        else $error("order or latency not captured");
endmodule // ffrc_top

// file: sim/ffrc_host.sv
/*
 host model for the strap side of the fifo control block.
 assumes straps move only while full reset is held low; after it the
 bench drives the offset access and serial bit pins.
*/
`timescale 1ns/10ps
module ffrc_host (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_full_reset_n,
    input wire logic [10:0] i_cfg,
    input wire logic i_access_n,
    input wire logic i_serial_bit,
    output logic [10:0] o_strap,
    output logic o_offset_access_enable_n
);
    logic [10:0] held;
    logic [10:0] next_held;
    // new strap levels only while full reset is low
    always_comb begin
        next_held = held;
        if (!i_full_reset_n) begin
            next_held = i_cfg;
        end
    end
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            held <= 11'h0;
        end else begin
            held <= next_held;
        end
    end
    // shared pin carries serial bits once full reset is over
    assign o_strap = {held[10:4], i_full_reset_n ? i_serial_bit : held[3], held[2:0]};
    // access pin is a strap in full reset, host driven afterwards
    assign o_offset_access_enable_n = i_full_reset_n ? i_access_n : held[0];
endmodule // ffrc_host

// file: sim/tb_ffrc_top.sv
/*
 self-checking bench for the fifo reset and strap control block.
 assumes one 100 MHz clock and the strap host model beside it.
*/
`timescale 1ns/10ps
module tb_ffrc_top;
    localparam logic [1:0] W36 = ffrc_pkg::WID_36;
    localparam logic [1:0] W18 = ffrc_pkg::WID_18;
    localparam logic [1:0] W9 = ffrc_pkg::WID_9;
    localparam logic [35:0] WA = 36'h804020100;
    localparam logic [35:0] WB = 36'h123456789;
    // offset words with parity position d8 set in both and d17 set in OFS_E
    localparam logic [35:0] OFS_E = 36'h0000357cd;
    localparam logic [35:0] OFS_F = 36'h000000123;
    // {empty, full} expected with and without interspersed parity
    localparam logic [35:0] OFS_IP = 36'h0abcd0023;
    localparam logic [35:0] OFS_NIP = 36'h057cd0123;
    localparam logic [31:0] SER = 32'h12345678;
    logic i_clk, i_rst_n, mrs_n, prs_n, rt_n, wen_n, ren_n, ld_n;
    logic acc_n, sen_n, si;
    logic [10:0] cfg, strap;
    logic [35:0] wd, o_read_data;
    logic o_empty_indicator_n, o_fall_through_mode, o_byte_order, o_reread_latency;
    logic o_almost_flag_timing, o_parity_placement, o_serial_load_mode;
    logic [1:0] o_write_width, o_read_width;
    logic [2:0] o_default_offset_sel;
    logic [15:0] o_empty_offset, o_full_offset;
    int miscompares = 0;
    int n_compared = 0;
    int cycles = 0;
    // rows: {bm,iw,ow,be,rm,pfm,ip,fall_through_mode,sel1,sel0,ld}, write width, read width
    logic [14:0] rows [8] = '{{11'b000_00000_000, W36, W36}, {11'b100_11111_001, W36, W18},
        {11'b101_01010_010, W36, W9}, {11'b110_10101_011, W18, W36},
        {11'b111_00110_100, W9, W36}, {11'b011_11001_101, W36, W36},
        {11'b100_01100_110, W36, W18}, {11'b010_10011_111, W36, W36}};

    ffrc_host ffrc_host_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_full_reset_n(mrs_n),
        .i_cfg(cfg), .i_access_n(acc_n), .i_serial_bit(si), .o_strap(strap),
        .o_offset_access_enable_n(ld_n));
    ffrc_top #(.DEPTH(16)) ffrc_top_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_full_reset_n(mrs_n), .i_partial_reset_n(prs_n), .i_reread_req_n(rt_n),
        .i_fallthrough_select_serial_in(strap[3]), .i_width_match_select(strap[10]),
        .i_write_width_select(strap[9]), .i_read_width_select(strap[8]),
        .i_byte_order_select(strap[7]), .i_reread_latency_select(strap[6]),
        .i_almost_flag_timing_select(strap[5]), .i_parity_placement_select(strap[4]),
        .i_default_offset_select_0(strap[1]), .i_default_offset_select_1(strap[2]),
        .i_offset_access_enable_n(ld_n), .i_serial_en_n(sen_n), .i_write_en_n(wen_n),
        .i_write_data_lines(wd), .i_read_en_n(ren_n), .o_read_data(o_read_data),
        .o_empty_indicator_n(o_empty_indicator_n), .o_fall_through_mode(o_fall_through_mode),
        .o_write_width(o_write_width), .o_read_width(o_read_width), .o_byte_order(o_byte_order),
        .o_reread_latency(o_reread_latency), .o_almost_flag_timing(o_almost_flag_timing),
        .o_parity_placement(o_parity_placement), .o_default_offset_sel(o_default_offset_sel),
        .o_serial_load_mode(o_serial_load_mode), .o_empty_offset(o_empty_offset),
        .o_full_offset(o_full_offset));

    initial begin
        i_clk = 1'h0;
        forever #5 i_clk = ~i_clk;
    end

    task automatic complete_run;
        $display("compares %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            complete_run();
        end
    end

    task automatic chk(input logic [35:0] seen, input logic [35:0] want);
        n_compared++;
        if (seen !== want) begin
            miscompares++;
            $display("BAD t=%0t seen %h want %h", $time, seen, want);
        end
    endtask

    // full reset held low for three edges; returns just after the release edge
    task automatic full_rst(input logic [10:0] c);
        cfg <= c;
        mrs_n <= 1'h0;
        repeat (3) @(posedge i_clk);
        mrs_n <= 1'h1;
        @(posedge i_clk);
        #1;
    endtask

    task automatic put(input logic [35:0] d);
        wen_n <= 1'h0;
        wd <= d;
        @(posedge i_clk);
        wen_n <= 1'h1;
        @(posedge i_clk);
    endtask

    task automatic take(input logic [35:0] want);
        ren_n <= 1'h0;
        @(posedge i_clk);
        ren_n <= 1'h1;
        #1;
        chk(o_read_data, want);
        @(posedge i_clk);
    endtask

    initial begin
        i_rst_n = 1'h0;
        mrs_n = 1'h1;
        prs_n = 1'h1;
        rt_n = 1'h1;
        wen_n = 1'h1;
        ren_n = 1'h1;
        wd = 36'h0;
        cfg = 11'h0;
        acc_n = 1'h1;
        sen_n = 1'h1;
        si = 1'h0;
        repeat (5) @(posedge i_clk);
        i_rst_n <= 1'h1;
        @(posedge i_clk);
        #1;
        chk(36'({o_write_width, o_read_width, o_empty_offset}),
            36'({W36, W36, ffrc_pkg::DEF_OFS[0]}));
        chk(o_read_data, 36'h0);
        $display("test reset done");
        for (int r = 0; r < 8; r++) begin
            @(posedge i_clk);
            full_rst(rows[r][14:4]);
            chk(36'(o_write_width), 36'(rows[r][3:2]));
            chk(36'(o_read_width), 36'(rows[r][1:0]));
            chk(36'(o_fall_through_mode), 36'(rows[r][7]));
            chk(36'({o_byte_order, o_reread_latency, o_almost_flag_timing,
                o_parity_placement}), 36'(rows[r][11:8]));
            chk(36'(o_default_offset_sel), 36'(rows[r][6:4]));
            chk(36'(o_serial_load_mode), 36'(rows[r][4]));
            chk(36'({o_empty_offset, o_full_offset}), 36'({ffrc_pkg::DEF_OFS[rows[r][6:4]],
                ffrc_pkg::DEF_OFS[rows[r][6:4]]}));
        end
        $display("test straps done");
        @(posedge i_clk);
        full_rst(11'b000_00010_001);
        @(posedge i_clk);
        put(WA);
        put(WB);
        take(WA);
        rt_n <= 1'h0;
        @(posedge i_clk);
        rt_n <= 1'h1;
        #1;
        chk(o_read_data, WA);
        chk(36'(o_empty_indicator_n), 36'h0);
        @(posedge i_clk);
        #1;
        chk(36'(o_empty_indicator_n), 36'h1);
        @(posedge i_clk);
        take(WB);
        put(WA);
        prs_n <= 1'h0;
        @(posedge i_clk);
        prs_n <= 1'h1;
        #1;
        chk(o_read_data, 36'h0);
        chk(36'(o_empty_indicator_n), 36'h0);
        chk(36'({o_parity_placement, o_empty_offset}),
            36'({1'h1, ffrc_pkg::DEF_OFS[1]}));
        @(posedge i_clk);
        put(WB);
        take(WB);
        $display("test reread and partial reset done");
        for (int b = 0; b < 2; b++) begin
            full_rst({3'b101, b[0], 7'b0000001});
            chk(o_read_data, 36'h0);
            @(posedge i_clk);
            put(WB);
            for (int k = 0; k < 4; k++) begin
                take(b ? 36'(WB[9*k +: 9]) : 36'(WB[35-9*k -: 9]));
            end
        end
        full_rst(11'b111_00000_001);
        @(posedge i_clk);
        for (int k = 0; k < 4; k++) begin
            put({27'h7ffffff, WB[35-9*k -: 9]});
        end
        take(WB);
        $display("test bus matching done");
        @(posedge i_clk);
        full_rst(11'b000_01001_001);
        @(posedge i_clk);
        put(WA);
        put(WB);
        #1;
        chk(o_read_data, WA);
        chk(36'(o_empty_indicator_n), 36'h0);
        @(posedge i_clk);
        take(WB);
        rt_n <= 1'h0;
        @(posedge i_clk);
        rt_n <= 1'h1;
        #1;
        chk(o_read_data, WB);
        chk(36'(o_empty_indicator_n), 36'h1);
        @(posedge i_clk);
        #1;
        chk(o_read_data, WA);
        chk(36'(o_empty_indicator_n), 36'h0);
        $display("test fall-through reread done");
        for (int p = 0; p < 2; p++) begin
            @(posedge i_clk);
            full_rst({6'b000000, p[0], 4'b0000});
            @(posedge i_clk);
            acc_n <= 1'h0;
            put(OFS_E);
            put(OFS_F);
            acc_n <= 1'h1;
            @(posedge i_clk);
            #1;
            chk(36'({o_empty_offset, o_full_offset}), p ? OFS_IP : OFS_NIP);
        end
        @(posedge i_clk);
        full_rst(11'b000_00000_001);
        @(posedge i_clk);
        acc_n <= 1'h0;
        sen_n <= 1'h0;
        for (int k = 31; k >= 0; k--) begin
            si <= SER[k];
            @(posedge i_clk);
        end
        acc_n <= 1'h1;
        sen_n <= 1'h1;
        @(posedge i_clk);
        #1;
        chk(36'({o_full_offset, o_empty_offset}), 36'(SER));
        $display("test offset loading done");
        complete_run();
    end
endmodule // tb_ffrc_top
